/* File: verilog/tsp_consts.svh */
`ifndef TSP_CONSTS_SVH
`define TSP_CONSTS_SVH

// Fixed upper four bits of the 7-bit slave address
`define TSP_DEV_TYPE 4'h9
// Index of the last bit of a byte
`define TSP_BIT_LAST 3'h7
// Reset and idle values
`define TSP_CNT_ZERO 3'h0
`define TSP_BYTE_ZERO 8'h00
`define TSP_BUS_IDLE 2'h3
// Polarity select level for an active-low alert
`define TSP_POL_LOW 1'h0
// Mode select level for interrupt mode
`define TSP_MODE_INT 1'h1

`endif

/* File: verilog/tsp_pkg.sv */
`default_nettype none

package tsp_pkg;

    typedef enum logic [5:0] {
        st_idle = 6'h01,
        st_addr = 6'h02,
        st_ack  = 6'h04,
        st_rx   = 6'h08,
        st_tx   = 6'h10,
        st_mack = 6'h20
    } tsp_state_t;

endpackage : tsp_pkg

`default_nettype wire

/* File: verilog/tsp_sync2.sv */
`timescale 1ns/1ns
`default_nettype none

module tsp_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            meta <= RST_VAL;
            q_out <= RST_VAL;
        end else begin
            meta <= d_in;
            q_out <= meta;
        end
    end

endmodule : tsp_sync2

`default_nettype wire

/* File: verilog/tsp_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tsp_consts.svh"

module tsp_top (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic scl_clk_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic [2:0] address_select_pins_in,
    input wire logic alert_mode_select_in,
    input wire logic alert_polarity_select_in,
    input wire logic temp_high_in,
    input wire logic temp_low_in,
    input wire logic [7:0] tx_byte_in,
    output logic alert_out,
    output logic alert_oe_out,
    output logic [7:0] rx_byte_out,
    output logic rx_valid_out,
    output logic tx_take_out
);

    // Link domain: capture on the serial clock itself
    logic [7:0] link_shift;
    logic link_tog;
    logic [7:0] next_link_shift;
    logic next_link_tog;

    always_comb begin
        next_link_shift = {link_shift[6:0], sda_in};
        next_link_tog = ~link_tog;
    end

    always_ff @(posedge scl_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            link_shift <= `TSP_BYTE_ZERO;
            link_tog <= 1'b0;
        end else begin
            link_shift <= next_link_shift;
            link_tog <= next_link_tog;
        end
    end

    // Crossings into the system clock domain
    logic [1:0] bus_s;
    logic tog_s;
    logic [2:0] addr_s;

    // Idle bus reads high, so no false start after reset
    tsp_sync2 #(.WIDTH(2), .RST_VAL(`TSP_BUS_IDLE)) u_bus_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .d_in({scl_clk_in, sda_in}),
        .q_out(bus_s)
    );

    tsp_sync2 #(.WIDTH(1), .RST_VAL(1'b0)) u_tog_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .d_in(link_tog),
        .q_out(tog_s)
    );

    // Open pins resolve to zero outside; read like any strap
    tsp_sync2 #(.WIDTH(3), .RST_VAL(3'h0)) u_addr_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .d_in(address_select_pins_in),
        .q_out(addr_s)
    );

    logic scl_s;
    logic sda_s;
    logic scl_d;
    logic sda_d;
    logic tog_d;
    logic scl_fall;
    logic start;
    logic stop;
    logic tog_ev;
    logic match;

    assign scl_s = bus_s[1];
    assign sda_s = bus_s[0];

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            tog_d <= 1'b0;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            tog_d <= tog_s;
        end
    end

    always_comb begin
        scl_fall = scl_d & ~scl_s;
        start = scl_d & scl_s & sda_d & ~sda_s;
        stop = scl_d & scl_s & ~sda_d & sda_s;
        // Captured byte is stable until the next rising edge, long after this
        tog_ev = tog_s ^ tog_d;
        match = (link_shift[7:1] == {`TSP_DEV_TYPE, addr_s});
    end

    // Protocol group
    tsp_pkg::tsp_state_t state;
    tsp_pkg::tsp_state_t next_state;
    logic [2:0] cnt;
    logic [2:0] next_cnt;
    logic rw;
    logic next_rw;
    logic [7:0] tx_shift;
    logic [7:0] next_tx_shift;
    logic next_sda_oe;
    logic [7:0] next_rx_byte;
    logic next_rx_valid;
    logic next_tx_take;
    logic rd_hit;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_rw = rw;
        next_tx_shift = tx_shift;
        next_sda_oe = sda_oe_out;
        next_rx_byte = rx_byte_out;
        next_rx_valid = 1'b0;
        next_tx_take = 1'b0;
        rd_hit = 1'b0;
        if (stop) begin
            next_state = tsp_pkg::st_idle;
            next_sda_oe = 1'b0;
        end else if (start) begin
            next_state = tsp_pkg::st_addr;
            next_cnt = `TSP_CNT_ZERO;
            next_sda_oe = 1'b0;
        end else begin
            if (tog_ev) begin
                case (state)
                    tsp_pkg::st_addr: begin
                        if (cnt == `TSP_BIT_LAST) begin
                            if (match) begin
                                next_state = tsp_pkg::st_ack;
                                next_rw = link_shift[0];
                                rd_hit = link_shift[0];
                            end else begin
                                next_state = tsp_pkg::st_idle;
                            end
                        end else begin
                            next_cnt = cnt + 3'h1;
                        end
                    end
                    tsp_pkg::st_ack: begin
                        next_cnt = `TSP_CNT_ZERO;
                        if (rw) begin
                            next_state = tsp_pkg::st_tx;
                            next_tx_shift = tx_byte_in;
                            next_tx_take = 1'b1;
                        end else begin
                            next_state = tsp_pkg::st_rx;
                        end
                    end
                    tsp_pkg::st_rx: begin
                        if (cnt == `TSP_BIT_LAST) begin
                            next_state = tsp_pkg::st_ack;
                            next_rx_byte = link_shift;
                            next_rx_valid = 1'b1;
                        end else begin
                            next_cnt = cnt + 3'h1;
                        end
                    end
                    tsp_pkg::st_tx: begin
                        if (cnt == `TSP_BIT_LAST) begin
                            next_state = tsp_pkg::st_mack;
                        end else begin
                            next_cnt = cnt + 3'h1;
                        end
                    end
                    tsp_pkg::st_mack: begin
                        // Master acknowledge asks for another byte
                        if (!link_shift[0]) begin
                            next_state = tsp_pkg::st_tx;
                            next_cnt = `TSP_CNT_ZERO;
                            next_tx_shift = tx_byte_in;
                            next_tx_take = 1'b1;
                        end else begin
                            next_state = tsp_pkg::st_idle;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (scl_fall) begin
                case (state)
                    tsp_pkg::st_ack: begin
                        next_sda_oe = 1'b1;
                    end
                    tsp_pkg::st_tx: begin
                        next_sda_oe = ~tx_shift[7];
                        next_tx_shift = {tx_shift[6:0], 1'b0};
                    end
                    default: begin
                        next_sda_oe = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= tsp_pkg::st_idle;
            cnt <= `TSP_CNT_ZERO;
            rw <= 1'b0;
            tx_shift <= `TSP_BYTE_ZERO;
            sda_oe_out <= 1'b0;
            sda_out <= 1'b0;
            rx_byte_out <= `TSP_BYTE_ZERO;
            rx_valid_out <= 1'b0;
            tx_take_out <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            rw <= next_rw;
            tx_shift <= next_tx_shift;
            sda_oe_out <= next_sda_oe;
            sda_out <= 1'b0;
            rx_byte_out <= next_rx_byte;
            rx_valid_out <= next_rx_valid;
            tx_take_out <= next_tx_take;
        end
    end

    // Alert group
    logic comp_on;
    logic next_comp_on;
    logic int_pend;
    logic next_int_pend;
    logic watch_high;
    logic next_watch_high;
    logic alert_on;
    logic next_alert_oe;

    always_comb begin
        next_comp_on = comp_on;
        next_int_pend = int_pend;
        next_watch_high = watch_high;
        if (temp_high_in) begin
            next_comp_on = 1'b1;
        end else if (temp_low_in) begin
            next_comp_on = 1'b0;
        end
        if (alert_mode_select_in == `TSP_MODE_INT) begin
            if (rd_hit) begin
                next_int_pend = 1'b0;
            end
            // A new crossing wins over a clearing read
            if (watch_high ? temp_high_in : temp_low_in) begin
                next_int_pend = 1'b1;
                next_watch_high = ~watch_high;
            end
        end else begin
            next_int_pend = 1'b0;
            next_watch_high = 1'b1;
        end
        alert_on = (alert_mode_select_in == `TSP_MODE_INT) ? int_pend : comp_on;
        // Pull low when active-low and on, or active-high and off
        next_alert_oe = alert_on ^ alert_polarity_select_in;
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            comp_on <= 1'b0;
            int_pend <= 1'b0;
            watch_high <= 1'b1;
            alert_oe_out <= 1'b0;
            alert_out <= 1'b0;
        end else begin
            comp_on <= next_comp_on;
            int_pend <= next_int_pend;
            watch_high <= next_watch_high;
            alert_oe_out <= next_alert_oe;
            alert_out <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence addr_last_s;
        state == tsp_pkg::st_addr && tog_ev && cnt == `TSP_BIT_LAST && !start && !stop;
    endsequence

    AST_ACK_ON_MATCH: assert property (
        addr_last_s ##0 match |=> state == tsp_pkg::st_ack
    ) else $error("matching address not taken to acknowledge");

    AST_NO_ACK_MISMATCH: assert property (
        addr_last_s ##0 !match |=> state == tsp_pkg::st_idle ##1 !sda_oe_out
    ) else $error("mismatched address was acknowledged");

    AST_SDA_ON_FALL: assert property (
        $changed(sda_oe_out) |-> $past(scl_fall) || $past(start) || $past(stop)
    ) else $error("data line changed away from a falling clock edge");

    AST_ACK_DRIVES_LOW: assert property (
        state == tsp_pkg::st_ack && scl_fall && !start && !stop |=> sda_oe_out && !sda_out
    ) else $error("acknowledge not driven low");

    AST_ADDR_FROM_PINS: assert property (
        addr_last_s ##0 (link_shift[3:1] != $past(address_select_pins_in, 2)) |=> state == tsp_pkg::st_idle
    ) else $error("address match ignores select pins");

    AST_COMP_ALERT: assert property (
        (alert_mode_select_in != `TSP_MODE_INT && temp_high_in
            && $stable(alert_polarity_select_in))[*2]
        |=> alert_oe_out == !alert_polarity_select_in
    ) else $error("comparator alert not raised above limit");

    AST_INT_STICKY: assert property (
        alert_mode_select_in == `TSP_MODE_INT && int_pend && !rd_hit
        |=> int_pend || alert_mode_select_in != `TSP_MODE_INT
    ) else $error("interrupt alert dropped without a read");

    AST_POL_LOW_ACTIVE: assert property (
        alert_on && alert_polarity_select_in == `TSP_POL_LOW |=> alert_oe_out
    ) else $error("active-low alert not pulled low");

    AST_INACTIVE_RELEASED: assert property (
        (alert_mode_select_in != `TSP_MODE_INT && temp_low_in && !temp_high_in
            && alert_polarity_select_in == `TSP_POL_LOW)[*2]
        |=> !alert_oe_out && !alert_out
    ) else $error("inactive alert not released");

endmodule : tsp_top

`default_nettype wire

/* File: bench/tsp_host_model.sv */
`timescale 1ns/1ns
`default_nettype none

module tsp_host_model (
    input wire logic lclk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_oe_out
);
    initial begin
        scl_out = 1'h1; // Clock stands high between frames
        sda_oe_out = 1'h0;
    end
    task automatic hp();
        repeat (10) @(posedge lclk_in);
    endtask : hp
    // One clock: data set mid-low, sampled at end of high
    task automatic bit_io(input logic b, output logic seen);
        sda_oe_out = ~b;
        hp();
        scl_out = 1'h1;
        hp();
        seen = sda_in;
        scl_out = 1'h0;
        hp();
    endtask : bit_io
    task automatic start();
        sda_oe_out = 1'h1;
        hp();
        scl_out = 1'h0;
        hp();
    endtask : start
    task automatic stop();
        sda_oe_out = 1'h1;
        hp();
        scl_out = 1'h1;
        hp();
        sda_oe_out = 1'h0;
        hp();
    endtask : stop
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'h1, s);
        ack = ~s;
    endtask : send_byte
    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'h1, b[i]);
        bit_io(~ack, s);
    endtask : recv_byte
endmodule : tsp_host_model

`default_nettype wire

/* File: bench/tb_tsp_top.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_tsp_top;
    logic clk_in = 1'h0;
    logic lclk = 1'h0;
    logic rst = 1'h1;
    logic scl, m_oe, sda_w, sda_out, sda_oe, alert, alert_oe, rx_valid, tx_take;
    logic mode = 1'h0;
    logic alert_polarity_select = 1'h0;
    logic thi = 1'h0;
    logic tlo = 1'h0;
    logic prev_oe = 1'h0;
    logic [2:0] pins = 3'h0;
    logic [7:0] tx_byte = 8'h3C;
    logic [7:0] rx_byte;
    int n_fail = 0;
    int compares = 0;
    int n_rx = 0;
    int n_take = 0;
    int cyc = 0;

    always #5 clk_in = ~clk_in;
    // Link clock offset by 1 ns; with a 3 ns half period its edges still meet some system clock rising edges, as at 25 ns
    initial begin
        #1;
        forever #3 lclk = ~lclk;
    end
    assign sda_w = ~(m_oe | sda_oe); // Wired-AND with pull-up

    tsp_top i_tsp_top (.clk_in(clk_in), .sys_rst_in(rst), .scl_clk_in(scl),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe),
        .address_select_pins_in(pins), .alert_mode_select_in(mode),
        .alert_polarity_select_in(alert_polarity_select), .temp_high_in(thi), .temp_low_in(tlo),
        .tx_byte_in(tx_byte), .alert_out(alert), .alert_oe_out(alert_oe),
        .rx_byte_out(rx_byte), .rx_valid_out(rx_valid), .tx_take_out(tx_take));
    tsp_host_model i_tsp_host_model (.lclk_in(lclk), .sda_in(sda_w), .scl_out(scl),
        .sda_oe_out(m_oe));

    task automatic summarize();
        if (n_fail == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", name, exp, got);
        end
    endtask : check

    always @(posedge clk_in) begin
        cyc++;
        if (rx_valid === 1'h1) n_rx++;
        if (tx_take === 1'h1) n_take++;
        if (sda_oe !== prev_oe && scl !== 1'h0) begin
            n_fail++;
            $display("BAD sda_oe_edge exp %h got %h", prev_oe, sda_oe);
        end
        if (sda_out !== 1'h0 || alert !== 1'h0) begin
            n_fail++;
            $display("BAD drive_level exp 0 got %h", {sda_out, alert});
        end
        prev_oe <= sda_oe;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end
    // Next transmit byte once the current one is taken
    always @(negedge clk_in) if (tx_take === 1'h1) tx_byte <= ~tx_byte;

    task automatic t_write();
        logic ack;
        int r0;
        @(negedge clk_in);
        pins = 3'h5;
        r0 = n_rx;
        repeat (4) @(negedge clk_in);
        i_tsp_host_model.start();
        i_tsp_host_model.send_byte(8'h9A, ack);
        check("addr_ack", 8'h01, 8'(ack));
        i_tsp_host_model.send_byte(8'hA5, ack);
        check("data_ack", 8'h01, 8'(ack));
        i_tsp_host_model.stop();
        check("rx_byte", 8'hA5, rx_byte);
        check("rx_count", 8'h01, 8'(n_rx - r0));
    endtask : t_write

    task automatic t_mismatch();
        logic ack;
        int r0;
        r0 = n_rx;
        i_tsp_host_model.start();
        i_tsp_host_model.send_byte(8'h90, ack);
        check("miss_ack", 8'h00, 8'(ack));
        i_tsp_host_model.send_byte(8'h9A, ack);
        check("miss_data_ack", 8'h00, 8'(ack));
        i_tsp_host_model.stop();
        check("miss_rx_count", 8'h00, 8'(n_rx - r0));
    endtask : t_mismatch

    task automatic t_read();
        logic ack;
        logic [7:0] b;
        int t0;
        @(negedge clk_in);
        pins = 3'h0; // Open pins read as zero
        t0 = n_take;
        repeat (4) @(negedge clk_in);
        i_tsp_host_model.start();
        i_tsp_host_model.send_byte(8'h91, ack);
        check("rd_addr_ack", 8'h01, 8'(ack));
        i_tsp_host_model.recv_byte(1'h1, b);
        check("rd_byte0", 8'h3C, b);
        i_tsp_host_model.recv_byte(1'h0, b);
        check("rd_byte1", 8'hC3, b);
        i_tsp_host_model.stop();
        check("take_count", 8'h02, 8'(n_take - t0));
    endtask : t_read

    task automatic read_clear();
        logic ack;
        logic [7:0] b;
        i_tsp_host_model.start();
        i_tsp_host_model.send_byte(8'h91, ack);
        i_tsp_host_model.recv_byte(1'h0, b);
        i_tsp_host_model.stop();
    endtask : read_clear

    task automatic step(input logic h, input logic l, input logic exp, input string name);
        @(negedge clk_in);
        thi = h;
        tlo = l;
        repeat (4) @(negedge clk_in);
        check(name, 8'(exp), 8'(alert_oe));
    endtask : step

    task automatic t_ara();
        logic ack;
        i_tsp_host_model.start();
        i_tsp_host_model.send_byte(8'h19, ack); // Alert response address, read
        check("ara_ack", 8'h00, 8'(ack));
        i_tsp_host_model.stop();
    endtask : t_ara

    task automatic t_alert();
        check("alert_idle", 8'h00, 8'(alert_oe));
        step(1'h1, 1'h0, 1'h1, "cmp_on");
        step(1'h0, 1'h0, 1'h1, "cmp_hold");
        step(1'h0, 1'h1, 1'h0, "cmp_off");
        alert_polarity_select = 1'h1;
        step(1'h0, 1'h0, 1'h1, "pol_idle");
        step(1'h1, 1'h0, 1'h0, "pol_on");
        step(1'h0, 1'h1, 1'h1, "pol_off");
        alert_polarity_select = 1'h0; // Shared alert lines stay active-low
        mode = 1'h1;
        step(1'h0, 1'h0, 1'h0, "int_idle");
        step(1'h1, 1'h0, 1'h1, "int_hi");
        step(1'h0, 1'h0, 1'h1, "int_pend");
        t_ara();
        step(1'h0, 1'h0, 1'h1, "int_ara_hold");
        read_clear();
        step(1'h0, 1'h0, 1'h0, "int_clr");
        step(1'h1, 1'h0, 1'h0, "int_rearm");
        step(1'h0, 1'h1, 1'h1, "int_lo");
        read_clear();
        step(1'h0, 1'h0, 1'h0, "int_clr2");
    endtask : t_alert

    initial begin
        repeat (20) @(posedge clk_in);
        @(negedge clk_in);
        rst = 1'h0;
        repeat (5) @(negedge clk_in);
        t_write();
        t_mismatch();
        t_read();
        t_alert();
        summarize();
    end
endmodule : tb_tsp_top

`default_nettype wire
